// ---- verilog/isfp_sequencer.sv ----
`timescale 1ns/10ps
// Operation
// - Read result left in data register
// - Trigger starts operation, holds CPU
// - Go bit self-clears, always reads zero
// - Trigger needs AA then 55 unlock
// - Decode read, program, erase function codes
// - Function 1011 returns maker identification byte
// - Erase clears aligned 128-byte page
// - Loader writable from application only with enable
// - Application code cannot touch option bytes
// - Lock keeps loader option access working
// - Block jumps between application and loader
// - Option bytes apply after reset only
// - Each region may read itself
// - Disabled sequencer ignores trigger writes
// - Enable runs internal RC oscillator
// - Enable bit guarded by same unlock
// - Illegal access sets fault flag
// - Address from high and low registers
module isfp_sequencer #(
  parameter logic [7:0] MAKER_ID     = 8'h5a, // Arbitrary value
  parameter int         APP_BYTES    = 16384,
  parameter int         DATA_BASE    = 14336,
  parameter int         LOADER_BYTES = 2048,
  parameter int         OPTION_BYTES = 4
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  output logic             cpu_hold,
  input  wire logic        run_from_loader,
  input  wire logic        booted_from_loader,
  input  wire logic        ext_clk_sel,
  output logic             rc_osc_en,
  output logic             boot_next_loader,
  output logic             flash_req,
  output logic             flash_read,
  output logic             flash_prog,
  output logic             flash_erase,
  output logic      [17:0] flash_addr,
  output logic      [7:0]  flash_wdata,
  input  wire logic [7:0]  flash_rdata,
  input  wire logic        flash_ack,
  input  wire logic [7:0]  option_nv,
  input  wire logic        reset_is_soft,
  output logic      [7:0]  option_active,
  input  wire logic        fetch_valid,
  input  wire logic        fetch_target_loader,
  output logic             jump_block
);
  typedef enum logic [1:0] {st_idle, st_access, st_done} isfp_state_t;

  isfp_state_t state_reg;
  logic [7:0]  data_reg;
  logic [7:0]  cmd_reg;
  logic [7:0]  addr_hi_reg;
  logic [7:0]  addr_lo_reg;
  logic        en_reg;
  logic        loader_update_enable_reg;
  logic        fault_reg;
  logic        boot_reg;
  logic        go_reg;
  logic [7:0]  rdata_reg;
  logic        req_reg;
  logic        rd_reg;
  logic        pg_reg;
  logic        er_reg;
  logic [17:0] faddr_reg;
  logic [7:0]  fwdata_reg;
  logic [6:0]  opt_low_reg;
  logic        opt_cbs_reg;
  logic        opt_loaded_reg;
  logic        ta_open;
  logic        wr_trig;
  logic        wr_chip;
  logic        accept;
  logic [3:0]  fn;
  logic [1:0]  region;
  logic [15:0] op_addr;
  logic        is_read;
  logic        is_prog;
  logic        is_erase;
  logic        is_id;
  logic        is_write;
  logic        oversize;
  logic        perm_bad;
  logic        illegal;
  logic        go_flash;

  isfp_ta_unlock u_unlock (
    .clk       (clk),
    .rstn      (rstn),
    .sfr_wr    (sfr_wr),
    .sfr_addr  (sfr_addr),
    .sfr_wdata (sfr_wdata),
    .ta_open   (ta_open)
  );

  assign fn       = cmd_reg[3:0];
  assign region   = cmd_reg[7:6];
  assign is_read  = fn == isfp_pkg::FN_READ && !cmd_reg[isfp_pkg::CMD_WSEL_BIT]
                    && !cmd_reg[isfp_pkg::CMD_CSEL_BIT];
  assign is_prog  = fn == isfp_pkg::FN_PROGRAM && cmd_reg[isfp_pkg::CMD_WSEL_BIT]
                    && !cmd_reg[isfp_pkg::CMD_CSEL_BIT];
  assign is_erase = fn == isfp_pkg::FN_ERASE && cmd_reg[isfp_pkg::CMD_WSEL_BIT]
                    && !cmd_reg[isfp_pkg::CMD_CSEL_BIT];
  assign is_id    = fn == isfp_pkg::FN_MAKER_ID && !cmd_reg[isfp_pkg::CMD_WSEL_BIT]
                    && !cmd_reg[isfp_pkg::CMD_CSEL_BIT];
  assign is_write = is_prog || is_erase;
  assign op_addr  = {addr_hi_reg, addr_lo_reg};

  always_comb begin
    case (region)
      isfp_pkg::REGION_APP:    oversize = {16'h0000, op_addr} >= APP_BYTES;
      isfp_pkg::REGION_LOADER: oversize = {16'h0000, op_addr} >= LOADER_BYTES;
      isfp_pkg::REGION_OPTION: oversize = ({16'h0000, op_addr} >= OPTION_BYTES)
                                 || (is_erase && op_addr != isfp_pkg::OPT_PAGE_ADDR);
      default:                 oversize = 1'b1;
    endcase
  end

  always_comb begin
    if (run_from_loader) begin
      perm_bad = is_write && region == isfp_pkg::REGION_LOADER;
    end else begin
      perm_bad = region == isfp_pkg::REGION_OPTION
                 || (is_write && region == isfp_pkg::REGION_LOADER && !loader_update_enable_reg)
                 || (is_write && region == isfp_pkg::REGION_APP
                     && {16'h0000, op_addr} < DATA_BASE);
    end
  end

  // Lock does not gate loader access
  assign illegal  = (is_read || is_write) && (oversize || perm_bad);
  assign go_flash = (is_read || is_write) && !illegal;

  assign wr_trig  = sfr_wr && sfr_addr == isfp_pkg::ADDR_TRIGGER;
  assign wr_chip  = sfr_wr && sfr_addr == isfp_pkg::ADDR_CHIP_CTRL && ta_open;
  assign accept   = wr_trig && ta_open && en_reg && sfr_wdata[isfp_pkg::TRIG_GO_BIT]
                    && state_reg == st_idle;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= st_idle;
    end else begin
      case (state_reg)
        st_idle: begin
          if (accept) state_reg <= go_flash ? st_access : st_done;
        end
        st_access: begin
          if (flash_ack) state_reg <= st_done;
        end
        st_done: state_reg <= st_idle;
        default: state_reg <= st_idle;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) go_reg <= 1'b0;
    else if (accept) go_reg <= 1'b1;
    else if (state_reg == st_done) go_reg <= 1'b0;
  end

  assign cpu_hold = go_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      req_reg    <= 1'b0;
      rd_reg     <= 1'b0;
      pg_reg     <= 1'b0;
      er_reg     <= 1'b0;
      faddr_reg  <= 18'h00000;
      fwdata_reg <= 8'h00;
    end else if (accept && go_flash) begin
      req_reg    <= 1'b1;
      rd_reg     <= is_read;
      pg_reg     <= is_prog;
      er_reg     <= is_erase;
      faddr_reg  <= {region, is_erase ? (op_addr & isfp_pkg::PAGE_MASK) : op_addr};
      fwdata_reg <= data_reg;
    end else if (state_reg == st_access && flash_ack) begin
      req_reg    <= 1'b0;
      rd_reg     <= 1'b0;
      pg_reg     <= 1'b0;
      er_reg     <= 1'b0;
    end
  end

  assign flash_req   = req_reg;
  assign flash_read  = rd_reg;
  assign flash_prog  = pg_reg;
  assign flash_erase = er_reg;
  assign flash_addr  = faddr_reg;
  assign flash_wdata = fwdata_reg;

  always_ff @(posedge clk) begin
    if (!rstn) data_reg <= isfp_pkg::DATA_RESET;
    else if (state_reg == st_access && flash_ack && rd_reg) data_reg <= flash_rdata;
    else if (accept && is_id) data_reg <= MAKER_ID;
    else if (sfr_wr && sfr_addr == isfp_pkg::ADDR_DATA) data_reg <= sfr_wdata;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmd_reg     <= isfp_pkg::COMMAND_RESET;
      addr_hi_reg <= isfp_pkg::ADDR_RESET;
      addr_lo_reg <= isfp_pkg::ADDR_RESET;
    end else if (sfr_wr) begin
      if (sfr_addr == isfp_pkg::ADDR_COMMAND) cmd_reg <= sfr_wdata;
      if (sfr_addr == isfp_pkg::ADDR_ADDR_HIGH) addr_hi_reg <= sfr_wdata;
      if (sfr_addr == isfp_pkg::ADDR_ADDR_LOW) addr_lo_reg <= sfr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      en_reg   <= 1'b0;
      loader_update_enable_reg <= 1'b0;
      boot_reg <= 1'b0;
    end else if (wr_chip) begin
      en_reg   <= sfr_wdata[isfp_pkg::CHIP_EN_BIT];
      loader_update_enable_reg <= sfr_wdata[isfp_pkg::CHIP_LOADER_UPDATE_ENABLE_BIT];
      boot_reg <= sfr_wdata[isfp_pkg::CHIP_BOOT_BIT];
    end
  end

  assign boot_next_loader = boot_reg;

  always_ff @(posedge clk) begin
    if (!rstn) fault_reg <= 1'b0;
    else if (accept && illegal) fault_reg <= 1'b1;
    else if (wr_chip && !sfr_wdata[isfp_pkg::CHIP_FAULT_BIT]) fault_reg <= 1'b0;
  end

  assign rc_osc_en = en_reg || !ext_clk_sel;

  assign jump_block = fetch_valid && (fetch_target_loader != run_from_loader);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      opt_loaded_reg <= 1'b0;
      opt_low_reg    <= isfp_pkg::OPTION_RESET[6:0];
    end else if (!opt_loaded_reg) begin
      opt_loaded_reg <= 1'b1;
      opt_low_reg    <= option_nv[6:0];
    end
  end

  // Boot select kept over soft reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      if (!reset_is_soft) opt_cbs_reg <= isfp_pkg::OPTION_RESET[isfp_pkg::OPT_CBS_BIT];
    end else if (!opt_loaded_reg && !reset_is_soft) begin
      opt_cbs_reg <= option_nv[isfp_pkg::OPT_CBS_BIT];
    end
  end

  assign option_active = {opt_cbs_reg, opt_low_reg};

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        isfp_pkg::ADDR_DATA:      rdata_reg <= data_reg;
        isfp_pkg::ADDR_COMMAND:   rdata_reg <= cmd_reg;
        isfp_pkg::ADDR_ADDR_HIGH: rdata_reg <= addr_hi_reg;
        isfp_pkg::ADDR_ADDR_LOW:  rdata_reg <= addr_lo_reg;
        isfp_pkg::ADDR_CHIP_CTRL: rdata_reg <= {1'b0, fault_reg, loader_update_enable_reg, 3'h0,
                                                booted_from_loader, en_reg};
        default:                  rdata_reg <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata = rdata_reg;

  property p_go_clear;
    @(posedge clk) disable iff (!rstn) state_reg == st_done |=> !cpu_hold;
  endproperty
  a_go_clear: assert property (p_go_clear) else $error("go bit not cleared");

  property p_hold;
    @(posedge clk) disable iff (!rstn) accept |=> cpu_hold && state_reg != st_idle;
  endproperty
  a_hold: assert property (p_hold) else $error("cpu not held");

  property p_trig_zero;
    @(posedge clk) disable iff (!rstn) sfr_rd && sfr_addr == isfp_pkg::ADDR_TRIGGER |=> sfr_rdata == 8'h00;
  endproperty
  a_trig_zero: assert property (p_trig_zero) else $error("trigger read nonzero");

  property p_disabled;
    @(posedge clk) disable iff (!rstn) state_reg == st_idle && !en_reg |=> state_reg == st_idle;
  endproperty
  a_disabled: assert property (p_disabled) else $error("start while disabled");

  property p_read_data;
    @(posedge clk) disable iff (!rstn)
      state_reg == st_access && flash_ack && flash_read |=> data_reg == $past(flash_rdata);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data lost");

  property p_maker;
    @(posedge clk) disable iff (!rstn) accept && is_id |=> data_reg == MAKER_ID ##1 !cpu_hold;
  endproperty
  a_maker: assert property (p_maker) else $error("bad id result");

  property p_align;
    @(posedge clk) disable iff (!rstn) flash_req && flash_erase |-> flash_addr[6:0] == 7'h00;
  endproperty
  a_align: assert property (p_align) else $error("erase not aligned");

  property p_app_opt;
    @(posedge clk) disable iff (!rstn)
      accept && (is_read || is_write) && !run_from_loader && region == isfp_pkg::REGION_OPTION
      |=> !flash_req && fault_reg;
  endproperty
  a_app_opt: assert property (p_app_opt) else $error("option access from app");

  property p_ldr_guard;
    @(posedge clk) disable iff (!rstn)
      accept && !run_from_loader && is_write && region == isfp_pkg::REGION_LOADER && !loader_update_enable_reg
      |=> !flash_req;
  endproperty
  a_ldr_guard: assert property (p_ldr_guard) else $error("loader write unguarded");

  property p_standby;
    @(posedge clk) disable iff (!rstn) accept && !go_flash |=> !flash_req [*2];
  endproperty
  a_standby: assert property (p_standby) else $error("standby touched flash");

  c_read:  cover property (@(posedge clk) disable iff (!rstn) accept && is_read ##[1:20] flash_ack);
  c_erase: cover property (@(posedge clk) disable iff (!rstn) flash_req && flash_erase);
  c_fault: cover property (@(posedge clk) disable iff (!rstn) accept && illegal);
endmodule : isfp_sequencer

// ---- verilog/isfp_pkg.sv ----
package isfp_pkg;
  // Special-function register addresses
  localparam logic [7:0]  ADDR_TRIGGER   = 8'ha4;
  localparam logic [7:0]  ADDR_ADDR_LOW  = 8'ha6;
  localparam logic [7:0]  ADDR_ADDR_HIGH = 8'ha7;
  localparam logic [7:0]  ADDR_DATA      = 8'hae;
  localparam logic [7:0]  ADDR_COMMAND   = 8'haf;
  localparam logic [7:0]  ADDR_CHIP_CTRL = 8'h9f;
  localparam logic [7:0]  ADDR_TA_KEY    = 8'hc7;
  // Unlock key bytes
  localparam logic [7:0]  KEY_FIRST      = 8'haa;
  localparam logic [7:0]  KEY_SECOND     = 8'h55;
  // Reset values
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  localparam logic [7:0]  COMMAND_RESET  = 8'h30;
  localparam logic [7:0]  ADDR_RESET     = 8'h00;
  localparam logic [7:0]  OPTION_RESET   = 8'h00;
  // Command fields
  localparam int          CMD_WSEL_BIT   = 5;
  localparam int          CMD_CSEL_BIT   = 4;
  localparam logic [3:0]  FN_READ        = 4'h0;
  localparam logic [3:0]  FN_PROGRAM     = 4'h1;
  localparam logic [3:0]  FN_ERASE       = 4'h2;
  localparam logic [3:0]  FN_MAKER_ID    = 4'hb;
  localparam logic [1:0]  REGION_APP     = 2'b00;
  localparam logic [1:0]  REGION_LOADER  = 2'b01;
  localparam logic [1:0]  REGION_OPTION  = 2'b11;
  // Chip control and trigger fields
  localparam int          CHIP_EN_BIT    = 0;
  localparam int          CHIP_BOOT_BIT  = 1;
  localparam int          CHIP_LOADER_UPDATE_ENABLE_BIT  = 5;
  localparam int          CHIP_FAULT_BIT = 6;
  localparam int          TRIG_GO_BIT    = 0;
  // Page geometry and option boot select bit
  localparam logic [15:0] PAGE_MASK      = 16'hff80;
  localparam logic [15:0] OPT_PAGE_ADDR  = 16'h0000;
  localparam int          OPT_CBS_BIT    = 7;
endpackage : isfp_pkg

// ---- verilog/isfp_ta_unlock.sv ----
`timescale 1ns/10ps
module isfp_ta_unlock (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  output logic            ta_open
);
  typedef enum logic [1:0] {ta_locked, ta_half, ta_ready} isfp_ta_t;
  isfp_ta_t ta_reg;
  logic     key_wr;

  assign key_wr  = sfr_wr && (sfr_addr == isfp_pkg::ADDR_TA_KEY);
  assign ta_open = (ta_reg == ta_ready);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ta_reg <= ta_locked;
    end else begin
      case (ta_reg)
        ta_locked: begin
          if (key_wr && sfr_wdata == isfp_pkg::KEY_FIRST) ta_reg <= ta_half;
        end
        ta_half: begin
          if (sfr_wr) begin
            if (key_wr && sfr_wdata == isfp_pkg::KEY_SECOND) ta_reg <= ta_ready;
            else ta_reg <= ta_locked;
          end
        end
        ta_ready: begin
          if (sfr_wr) ta_reg <= ta_locked;
        end
        default: ta_reg <= ta_locked;
      endcase
    end
  end
endmodule : isfp_ta_unlock

// ---- dv/isfp_flash_model.sv ----
`timescale 1ns/10ps
module isfp_flash_model (
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic        rd,
  input  wire logic        prog,
  input  wire logic        erase,
  input  wire logic [17:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata,
  output logic             ack
);
  logic [7:0] mem [logic [17:0]];
  int         cnt = 0;
  int         lat = 1;
  initial ack = 1'b0;
  initial rdata = 8'h00;
  // Latency cycles through 1..5, data toggles outside ack
  always @(posedge clk) begin
    rdata <= ~rdata;
    if (ack) begin
      ack <= 1'b0;
    end else if (req && cnt >= lat) begin
      ack <= 1'b1;
      cnt <= 0;
      lat <= lat % 5 + 1;
      if (rd) begin
        rdata <= mem.exists(addr) ? mem[addr] : 8'hff;
      end
      // Program clears bits only
      if (prog) begin
        mem[addr] = (mem.exists(addr) ? mem[addr] : 8'hff) & wdata;
      end
      if (erase) begin
        for (int i = 0; i < 128; i++) begin
          mem.delete({addr[17:7], i[6:0]});
        end
      end
    end else if (req) begin
      cnt <= cnt + 1;
    end
  end
endmodule : isfp_flash_model

// ---- dv/isfp_sequencer_tb.sv ----
`timescale 1ns/10ps
module isfp_sequencer_tb;
  logic        clk, rstn, sfr_wr, sfr_rd, run_ldr, fetch_valid, fetch_ldr;
  logic        cpu_hold, rc_osc_en, f_req, f_rd, f_prog, f_erase, f_ack, jump_block;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, f_wdata, f_rdata, option_active, wd;
  logic [17:0] f_addr;
  logic        ext_clk, soft_rst, boot_nl;
  logic [7:0]  opt_nv;
  logic        rd_d = 1'b0;
  logic [7:0]  exp_q [$];
  int          failures = 0;
  int          checks_done = 0;

  isfp_sequencer dut (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_hold(cpu_hold), .run_from_loader(run_ldr),
    .booted_from_loader(1'b0), .ext_clk_sel(ext_clk), .rc_osc_en(rc_osc_en), .boot_next_loader(boot_nl),
    .flash_req(f_req), .flash_read(f_rd), .flash_prog(f_prog), .flash_erase(f_erase), .flash_addr(f_addr),
    .flash_wdata(f_wdata), .flash_rdata(f_rdata), .flash_ack(f_ack), .option_nv(opt_nv),
    .reset_is_soft(soft_rst), .option_active(option_active), .fetch_valid(fetch_valid),
    .fetch_target_loader(fetch_ldr), .jump_block(jump_block));

  isfp_flash_model flash (.clk(clk), .req(f_req), .rd(f_rd), .prog(f_prog), .erase(f_erase),
    .addr(f_addr), .wdata(f_wdata), .rdata(f_rdata), .ack(f_ack));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Read results compared one cycle after the strobe
  always @(posedge clk) begin
    rd_d <= sfr_rd;
    if (rd_d) chk(sfr_rdata, exp_q.pop_front());
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    sfr_rd <= 1'b0;
  endtask : rd

  task automatic unlock();
    wr(isfp_pkg::ADDR_TA_KEY, isfp_pkg::KEY_FIRST);
    wr(isfp_pkg::ADDR_TA_KEY, isfp_pkg::KEY_SECOND);
  endtask : unlock

  task automatic go(input logic [7:0] cmd, input logic [15:0] a, input logic hold_exp);
    logic seen;
    seen = 1'b0;
    wr(isfp_pkg::ADDR_COMMAND, cmd);
    wr(isfp_pkg::ADDR_ADDR_HIGH, a[15:8]);
    wr(isfp_pkg::ADDR_ADDR_LOW, a[7:0]);
    unlock();
    wr(isfp_pkg::ADDR_TRIGGER, 8'h01);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (cpu_hold === 1'b1) seen = 1'b1;
      if (seen && cpu_hold === 1'b0) break;
    end
    chk({7'h0, seen}, {7'h0, hold_exp});
    chk({7'h0, cpu_hold}, 8'h00);
  endtask : go

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  initial begin
    #150000;
    failures++;
    test_done();
  end

  initial begin
    void'($urandom(32'hd4923378));
    {rstn, sfr_wr, sfr_rd, run_ldr, fetch_valid, fetch_ldr} = 6'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    ext_clk = 1'b1;
    soft_rst = 1'b0;
    opt_nv = 8'h9c;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk(option_active, 8'h9c);
    rd(isfp_pkg::ADDR_DATA, isfp_pkg::DATA_RESET);
    rd(isfp_pkg::ADDR_COMMAND, isfp_pkg::COMMAND_RESET);
    rd(isfp_pkg::ADDR_ADDR_HIGH, isfp_pkg::ADDR_RESET);
    rd(8'h00, 8'h00);
    $display("test reset values done");
    go(isfp_pkg::COMMAND_RESET, 16'h0000, 1'b0);
    wr(isfp_pkg::ADDR_COMMAND, isfp_pkg::COMMAND_RESET);
    unlock();
    wr(isfp_pkg::ADDR_CHIP_CTRL, 8'h01);
    go(isfp_pkg::COMMAND_RESET, 16'h0000, 1'b1);
    chk({7'h0, rc_osc_en}, 8'h01);
    wr(isfp_pkg::ADDR_TRIGGER, 8'h01);
    wr(isfp_pkg::ADDR_TA_KEY, isfp_pkg::KEY_FIRST);
    wr(isfp_pkg::ADDR_DATA, 8'h11);
    wr(isfp_pkg::ADDR_TA_KEY, isfp_pkg::KEY_SECOND);
    wr(isfp_pkg::ADDR_TRIGGER, 8'h01);
    @(posedge clk);
    chk({7'h0, cpu_hold}, 8'h00);
    $display("test unlock done");
    wd = 8'($urandom);
    wr(isfp_pkg::ADDR_DATA, wd);
    go(8'h21, 16'h3805, 1'b1);
    go(8'h00, 16'h3805, 1'b1);
    rd(isfp_pkg::ADDR_DATA, wd);
    go(8'h22, 16'h3805, 1'b1);
    go(8'h00, 16'h3805, 1'b1);
    rd(isfp_pkg::ADDR_DATA, 8'hff);
    rd(isfp_pkg::ADDR_TRIGGER, 8'h00);
    go(8'h0b, 16'hffff, 1'b1);
    rd(isfp_pkg::ADDR_DATA, 8'h5a);
    $display("test program erase read done");
    go(8'hc0, 16'h0000, 1'b1);
    rd(isfp_pkg::ADDR_CHIP_CTRL, 8'h41);
    rd(isfp_pkg::ADDR_DATA, 8'h5a);
    unlock();
    wr(isfp_pkg::ADDR_CHIP_CTRL, 8'h01);
    go(8'h61, 16'h0010, 1'b1);
    rd(isfp_pkg::ADDR_CHIP_CTRL, 8'h41);
    unlock();
    wr(isfp_pkg::ADDR_CHIP_CTRL, 8'h23);
    wr(isfp_pkg::ADDR_DATA, wd);
    go(8'h61, 16'h0010, 1'b1);
    rd(isfp_pkg::ADDR_CHIP_CTRL, 8'h21);
    chk({7'h0, boot_nl}, 8'h01);
    $display("test access rights done");
    run_ldr <= 1'b1;
    go(8'h40, 16'h0010, 1'b1);
    rd(isfp_pkg::ADDR_DATA, wd);
    // option bytes are the last flash update
    go(8'he2, 16'h0000, 1'b1);
    wd = 8'($urandom);
    wr(isfp_pkg::ADDR_DATA, wd);
    go(8'he1, 16'h0000, 1'b1);
    go(8'hc0, 16'h0000, 1'b1);
    rd(isfp_pkg::ADDR_DATA, wd);
    rd(isfp_pkg::ADDR_CHIP_CTRL, 8'h21);
    fetch_valid <= 1'b1;
    @(posedge clk);
    #1 chk({7'h0, jump_block}, 8'h01);
    fetch_ldr <= 1'b1;
    @(posedge clk);
    #1 chk({7'h0, jump_block}, 8'h00);
    $display("test loader done");
    go(isfp_pkg::COMMAND_RESET, 16'h0000, 1'b1);
    unlock();
    wr(isfp_pkg::ADDR_CHIP_CTRL, 8'h00);
    @(posedge clk);
    chk({7'h0, rc_osc_en}, 8'h00);
    go(isfp_pkg::COMMAND_RESET, 16'h0000, 1'b0);
    ext_clk <= 1'b0;
    @(posedge clk);
    chk({7'h0, rc_osc_en}, 8'h01);
    $display("test disable done");
    // options follow reset only, boot select kept over soft reset
    opt_nv <= 8'h15;
    soft_rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(option_active, 8'h9c);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk(option_active, 8'h95);
    $display("test option reset done");
    repeat (3) @(posedge clk);
    test_done();
  end
endmodule : isfp_sequencer_tb
